// [design/dbmc_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dbmc_regs.svh"
module dbmc_top
  import dbmc_pkg::*;
#(
  parameter int unsigned HOLD_CYC  = `DBMC_HOLD_CYC,
  parameter int unsigned FLASH_CYC = `DBMC_FLASH_CYC
)(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // pins from the board
  input  wire logic        protocol_select_switch,
  input  wire logic [7:0]  config_switch_bank,
  input  wire logic [2:0]  hall_in,
  input  wire logic        motor_supply_present,
  input  wire logic        motor_supply_over_86v,
  input  wire logic        safe_torque_input_ok,
  // CAN controller side
  input  wire logic        can_cmd_valid,
  input  wire logic        can_cmd_is_cia305,
  // outputs
  output var  logic        ready_led,
  output var  logic        error_led,
  output var  logic        pwm_enable,
  output var  logic        run_program,
  output var  logic        can_tx_enable,
  output var  logic        can_cmd_accept,
  output var  logic [7:0]  node_address,
  output var  logic        use_hall_commutation,
  output var  logic        use_encoder_position,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  dbmc_state_all_t r;
  dbmc_state_all_t next_r;
  logic [14:0]     pins;
  logic            hall_low;
  logic            sw_canopen;
  logic [7:0]      sw_node;
  logic            ovp;
  logic            sto_ok;
  logic            mot_ok;
  logic            wr_fire;

  // ****************************************
  // synchronised pins
  // ****************************************
  assign pins       = {config_switch_bank, protocol_select_switch, motor_supply_over_86v,
                       safe_torque_input_ok, motor_supply_present, hall_in};
  assign hall_low   = (r.sync1[2:0] == 3'h0);
  assign mot_ok     = r.sync1[3];
  assign sto_ok     = r.sync1[4];
  assign ovp        = r.sync1[5];
  assign sw_canopen = r.sync1[6];
  assign sw_node    = r.sync1[14:7];
  assign wr_fire    = r.bus.awdone && r.bus.wdone && !r.bus.bvalid;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_r       = r;
    next_r.sync0 = pins;
    next_r.sync1 = r.sync0;
    // no error before the synchronised pins hold real values
    next_r.error = r.sampled && (ovp || !sto_ok);
    case (r.state)
      DBMC_ST_SAMPLE:
      begin
        // straps need two edges through the synchroniser; caught once after each reset
        if (r.hold_cnt >= 32'h2)
        begin
          next_r.cfg.canopen         = sw_canopen;
          next_r.cfg.node_identifier = sw_node;
          next_r.sampled             = 1'b1;
          next_r.hold_cnt            = 32'h0;
          next_r.state               = DBMC_ST_HALL;
        end
        else
        begin
          next_r.hold_cnt = r.hold_cnt + 32'h1;
        end
      end
      DBMC_ST_HALL:
      begin
        if (!hall_low || r.cfg.canopen)
        begin
          next_r.state = DBMC_ST_DECIDE;
        end
        else if (r.hold_cnt >= HOLD_CYC - 1)
        begin
          next_r.state = DBMC_ST_SLAVE;
          next_r.init_done = 1'b1;
        end
        else
        begin
          next_r.hold_cnt = r.hold_cnt + 32'h1;
        end
      end
      DBMC_ST_DECIDE:
      begin
        next_r.init_done = 1'b1;
        if (r.cfg.canopen && r.cfg.node_identifier == `DBMC_NODE_UNCONFIG)
        begin
          next_r.state = DBMC_ST_UNCONF;
        end
        else if (r.cfg.canopen)
        begin
          next_r.state = DBMC_ST_SLAVE;
        end
        else if (!r.prog_valid || r.autorun_off)
        begin
          next_r.state = DBMC_ST_SLAVE;
        end
        else
        begin
          next_r.state = DBMC_ST_AUTORUN;
        end
      end
      DBMC_ST_UNCONF:
      begin
        if (r.flash_cnt >= FLASH_CYC - 1)
        begin
          next_r.flash_cnt = 32'h0;
          next_r.flash     = !r.flash;
        end
        else
        begin
          next_r.flash_cnt = r.flash_cnt + 32'h1;
        end
        if (r.cfg_done)
        begin
          next_r.state = DBMC_ST_SLAVE;
        end
      end
      DBMC_ST_SLAVE:
      begin
        next_r.flash = 1'b0;
      end
      DBMC_ST_AUTORUN:
      begin
        if (mot_ok && !r.cfg.canopen)
        begin
          next_r.run_prog = 1'b1;
        end
      end
      default:
      begin
        next_r.state = DBMC_ST_SAMPLE;
      end
    endcase
    if (r.state != DBMC_ST_AUTORUN)
    begin
      next_r.run_prog = 1'b0;
    end
    next_r.ready_led = r.init_done && !r.error &&
                       ((r.state == DBMC_ST_UNCONF) ? r.flash : 1'b1);
    next_r.error_led  = r.error;
    next_r.pwm_enable = sto_ok && !ovp && r.init_done;
    next_r.can_tx_enable = r.init_done && (r.state != DBMC_ST_UNCONF);
    next_r.can_cmd_accept = can_cmd_valid &&
                            ((r.state != DBMC_ST_UNCONF) ||
                             (can_cmd_is_cia305 == `DBMC_CMD_CIA305));
    next_r.node_address = (r.state == DBMC_ST_UNCONF || !r.init_done) ? 8'h00 :
                          (r.cfg_done ? r.cfg_node : r.cfg.node_identifier);
    next_r.use_hall_commutation = r.hall_fb;
    // position always comes from the encoder, halls only add commutation
    next_r.use_encoder_position = 1'b1;

    // ****************************************
    // axi4-lite slave
    // ****************************************
    if (s_axi_awvalid && !r.bus.awdone)
    begin
      next_r.bus.awdone = 1'b1;
      next_r.bus.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.bus.wdone)
    begin
      next_r.bus.wdone = 1'b1;
      next_r.bus.wdata = s_axi_wdata;
    end
    if (wr_fire)
    begin
      next_r.bus.bvalid = 1'b1;
      next_r.bus.bresp  = 2'b00;
      case (r.bus.awaddr)
        `DBMC_OFF_CTRL:
        begin
          next_r.prog_valid = r.bus.wdata[`DBMC_CTRL_PROG_VAL];
          next_r.cfg_done   = r.bus.wdata[`DBMC_CTRL_CFG_DONE];
          next_r.hall_fb    = r.bus.wdata[`DBMC_CTRL_HALL_FB];
        end
        `DBMC_OFF_CONFIG: next_r.cfg_node = r.bus.wdata[7:0];
        `DBMC_OFF_NVM_ADDR: next_r.nvm_addr = r.bus.wdata[15:0];
        `DBMC_OFF_NVM_DATA:
        begin
          if (r.nvm_addr == `DBMC_NVM_AUTORUN_ADDR)
          begin
            next_r.nvm_word0   = r.bus.wdata[15:0];
            next_r.autorun_off = (r.bus.wdata[15:0] == `DBMC_NVM_AUTORUN_OFF);
          end
        end
        `DBMC_OFF_STATUS, `DBMC_OFF_CAN_CMD: next_r.bus.bresp = 2'b00;
        default: next_r.bus.bresp = 2'b10;
      endcase
    end
    if (r.bus.bvalid && s_axi_bready)
    begin
      next_r.bus.bvalid = 1'b0;
      next_r.bus.awdone = 1'b0;
      next_r.bus.wdone  = 1'b0;
    end
    if (s_axi_arvalid && !r.bus.rvalid)
    begin
      next_r.bus.rvalid = 1'b1;
      next_r.bus.rresp  = 2'b00;
      case (s_axi_araddr)
        `DBMC_OFF_CTRL: next_r.bus.rdata = {26'h0, r.hall_fb, 1'b0, r.cfg_done, 1'b0,
                                            r.prog_valid, 1'b0};
        `DBMC_OFF_STATUS: next_r.bus.rdata = {16'h0, r.run_prog, r.error, r.pwm_enable,
                                              r.cfg.canopen, 1'b0, r.state, r.init_done,
                                              r.cfg.node_identifier[6:0]};
        `DBMC_OFF_CONFIG: next_r.bus.rdata = {23'h0, r.cfg.canopen, r.cfg.node_identifier};
        `DBMC_OFF_NVM_ADDR: next_r.bus.rdata = {16'h0, r.nvm_addr};
        `DBMC_OFF_NVM_DATA: next_r.bus.rdata = {16'h0, r.nvm_word0};
        `DBMC_OFF_CAN_CMD: next_r.bus.rdata = {24'h0, r.node_address};
        default:
        begin
          next_r.bus.rdata = 32'h0;
          next_r.bus.rresp = 2'b10;
        end
      endcase
    end
    else if (r.bus.rvalid && s_axi_rready)
    begin
      next_r.bus.rvalid = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign ready_led            = r.ready_led;
  assign error_led            = r.error_led;
  assign pwm_enable           = r.pwm_enable;
  assign run_program          = r.run_prog;
  assign can_tx_enable        = r.can_tx_enable;
  assign can_cmd_accept       = r.can_cmd_accept;
  assign node_address         = r.node_address;
  assign use_hall_commutation = r.use_hall_commutation;
  assign use_encoder_position = r.use_encoder_position;
  assign s_axi_awready        = !r.bus.awdone;
  assign s_axi_wready         = !r.bus.wdone;
  assign s_axi_bvalid         = r.bus.bvalid;
  assign s_axi_bresp          = r.bus.bresp;
  assign s_axi_arready        = !r.bus.rvalid;
  assign s_axi_rvalid         = r.bus.rvalid;
  assign s_axi_rdata          = r.bus.rdata;
  assign s_axi_rresp          = r.bus.rresp;
endmodule : dbmc_top
`default_nettype wire

// [design/dbmc_regs.svh]
`ifndef DBMC_REGS_SVH
`define DBMC_REGS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define DBMC_OFF_CTRL       8'h00
`define DBMC_OFF_STATUS     8'h04
`define DBMC_OFF_CONFIG     8'h08
`define DBMC_OFF_NVM_ADDR   8'h0C
`define DBMC_OFF_NVM_DATA   8'h10
`define DBMC_OFF_CAN_CMD    8'h14
// ****************************************
// field positions
// ****************************************
`define DBMC_CTRL_INIT_DONE 0
`define DBMC_CTRL_PROG_VAL  1
`define DBMC_CTRL_ERROR     2
`define DBMC_CTRL_CFG_DONE  3
`define DBMC_CTRL_NODE_SET  4
`define DBMC_CTRL_HALL_FB   5
// ****************************************
// reset values and constants
// ****************************************
`define DBMC_CTRL_RESET     32'h0000_0000
`define DBMC_NVM_AUTORUN_ADDR 16'h4000
`define DBMC_NVM_AUTORUN_OFF  16'h0001
`define DBMC_NODE_UNCONFIG  8'hFF
`define DBMC_CMD_CIA305     1'b1
// ****************************************
// timing
// ****************************************
`define DBMC_CLK_HZ         100000000
`define DBMC_HOLD_MS        1000
`define DBMC_HOLD_CYC       ((`DBMC_CLK_HZ / 1000) * `DBMC_HOLD_MS)
`define DBMC_FLASH_MS       1000
`define DBMC_FLASH_CYC      ((`DBMC_CLK_HZ / 1000) * `DBMC_FLASH_MS)
`endif

// [design/dbmc_pkg.sv]
package dbmc_pkg;
  typedef enum logic [2:0] {
    DBMC_ST_SAMPLE  = 3'b000,
    DBMC_ST_HALL    = 3'b001,
    DBMC_ST_DECIDE  = 3'b010,
    DBMC_ST_UNCONF  = 3'b011,
    DBMC_ST_SLAVE   = 3'b100,
    DBMC_ST_AUTORUN = 3'b101
  } dbmc_state_t;

  typedef struct packed {
    logic       canopen;
    logic [7:0] node_identifier;
  } dbmc_cfg_t;

  typedef struct packed {
    logic        awdone;
    logic [7:0]  awaddr;
    logic        wdone;
    logic [31:0] wdata;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dbmc_bus_t;

  typedef struct packed {
    dbmc_state_t state;
    dbmc_cfg_t   cfg;
    logic        sampled;
    logic [31:0] hold_cnt;
    logic [31:0] flash_cnt;
    logic        flash;
    logic        init_done;
    logic        prog_valid;
    logic        error;
    logic        cfg_done;
    logic [7:0]  cfg_node;
    logic        hall_fb;
    logic [15:0] nvm_addr;
    logic [15:0] nvm_word0;
    logic        autorun_off;
    logic        run_prog;
    logic        ready_led;
    logic        error_led;
    logic        pwm_enable;
    logic        can_tx_enable;
    logic        can_cmd_accept;
    logic [7:0]  node_address;
    logic        use_hall_commutation;
    logic        use_encoder_position;
    logic [14:0] sync0;
    logic [14:0] sync1;
    dbmc_bus_t   bus;
  } dbmc_state_all_t;
endpackage : dbmc_pkg

// [test/dbmc_can_master.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// network master issuing commands
// ****************************************
module dbmc_can_master (
  // clock
  input  wire logic aclk,
  // command link
  output var  logic can_cmd_valid,
  output var  logic can_cmd_is_cia305,
  input  wire logic can_cmd_accept
);
  initial
  begin
    can_cmd_valid     = 1'b0;
    can_cmd_is_cia305 = 1'b0;
  end
  task automatic send(input logic c, output logic acc);
    @(posedge aclk);
    can_cmd_valid     <= 1'b1;
    can_cmd_is_cia305 <= c;
    @(posedge aclk);
    can_cmd_valid     <= 1'b0;
    // qualifier means nothing off the pulse
    can_cmd_is_cia305 <= ~c;
    @(posedge aclk);
    acc = can_cmd_accept;
  endtask : send
endmodule : dbmc_can_master
`default_nettype wire

// [test/dbmc_top_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// run mode checks
// ****************************************
module dbmc_checker
  import dbmc_pkg::*;
#(
  parameter int unsigned HOLD_CYC  = 1,
  parameter int unsigned FLASH_CYC = 1
)(
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // pins
  input wire logic       protocol_select_switch,
  input wire logic       motor_supply_over_86v,
  input wire logic       safe_torque_input_ok,
  input wire logic       can_cmd_valid,
  input wire logic       can_cmd_is_cia305,
  // outputs
  input wire logic       ready_led,
  input wire logic       error_led,
  input wire logic       pwm_enable,
  input wire logic       run_program,
  input wire logic       can_tx_enable,
  input wire logic       can_cmd_accept,
  input wire logic [7:0] node_address,
  input wire logic       use_hall_commutation,
  input wire logic       use_encoder_position
);
  logic seen;
  logic proto_q;
  // protocol strap as taken at the first edge after reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seen    <= 1'b0;
      proto_q <= 1'b0;
    end
    else if (!seen)
    begin
      seen    <= 1'b1;
      proto_q <= protocol_select_switch;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence sto_gone;
    !safe_torque_input_ok [*5];
  endsequence
  sequence ov_held;
    motor_supply_over_86v [*5];
  endsequence
  a_pwm_needs_sto:
    assert property (sto_gone |-> !pwm_enable) else $error("pwm on without safe torque");
  a_ov_trip:
    assert property (ov_held |-> !pwm_enable && error_led) else $error("overvoltage not tripped");
  a_ready_error_off:
    assert property (error_led [*2] |-> !ready_led) else $error("ready lit during error");
  a_run_native_only:
    assert property (run_program |-> seen && !proto_q) else $error("autorun under canopen");
  a_accept_cause:
    assert property (can_cmd_accept |-> $past(can_cmd_valid)) else $error("accept without cmd");
  a_ignore_other:
    assert property (can_cmd_valid && !can_cmd_is_cia305 && !can_tx_enable |=> !can_cmd_accept)
      else $error("foreign cmd accepted");
  a_node_stable:
    assert property (can_tx_enable && $past(can_tx_enable) |-> $stable(node_address))
      else $error("node address moved");
  a_hall_encoder:
    assert property (use_hall_commutation |-> use_encoder_position) else $error("no encoder");
endmodule : dbmc_checker
bind dbmc_top dbmc_checker #(.HOLD_CYC(HOLD_CYC), .FLASH_CYC(FLASH_CYC)) chk_u (.*);
`default_nettype wire

// [test/test_drive_boot_mode_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dbmc_regs.svh"
// ****************************************
// boot and run mode bench
// ****************************************
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
`define WT(c) begin for (int i = 0; i < 300 && ((c) !== 1'b1); i++) @(posedge aclk); \
  if ((c) !== 1'b1) tmo(); end
module test_drive_boot_mode_control;
  import dbmc_pkg::*;
  localparam int HC = 20;
  localparam int FC = 10;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        protocol_select_switch = 1'b0;
  logic [7:0]  config_switch_bank = 8'h00;
  logic [2:0]  hall_in = 3'h0;
  logic        motor_supply_present = 1'b0;
  logic        motor_supply_over_86v = 1'b0;
  logic        safe_torque_input_ok = 1'b1;
  logic        can_cmd_valid, can_cmd_is_cia305, can_cmd_accept;
  logic        ready_led, error_led, pwm_enable, run_program, can_tx_enable;
  logic [7:0]  node_address;
  logic        use_hall_commutation, use_encoder_position;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] rd;
  logic        acc, fl;
  int          errors = 0;
  int          samples_checked = 0;
  dbmc_top #(.HOLD_CYC(HC), .FLASH_CYC(FC)) dut_u (.*);
  dbmc_can_master can_u (.aclk(aclk), .can_cmd_valid(can_cmd_valid),
    .can_cmd_is_cia305(can_cmd_is_cia305), .can_cmd_accept(can_cmd_accept));
  always #5 aclk = ~aclk;
  task automatic print_verdict;
    $display("checked %0d, bad %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic tmo;
    errors++;
    print_verdict();
  endtask : tmo
  task automatic boot(input logic p, input logic [7:0] n, input logic [2:0] h);
    @(posedge aclk);
    aresetn                <= 1'b0;
    protocol_select_switch <= p;
    config_switch_bank     <= n;
    hall_in                <= h;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : boot
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 50) tmo();
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 50) tmo();
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  initial
  begin
    // program stored, halls released before the hold runs out
    boot(1'b0, 8'h03, 3'h0);
    axw(`DBMC_OFF_CTRL, 32'h2);
    hall_in <= 3'h5;
    repeat (10) @(posedge aclk);
    `CHK("nomot", 1'b0, run_program)
    motor_supply_present <= 1'b1;
    `WT(run_program)
    axr(`DBMC_OFF_STATUS);
    `CHK("state", 3'h5, rd[10:8])
    `CHK("run", 1'b1, run_program)
    `CHK("ready", 1'b1, ready_led)
    `CHK("pwm", 1'b1, pwm_enable)
    `CHK("node", 8'h03, node_address)
    protocol_select_switch <= 1'b1;
    config_switch_bank     <= 8'h44;
    axr(`DBMC_OFF_CONFIG);
    `CHK("cfg", 9'h003, rd[8:0])
    motor_supply_over_86v <= 1'b1;
    `WT(error_led)
    `CHK("ov_pwm", 1'b0, pwm_enable)
    `CHK("ov_rdy", 1'b0, ready_led)
    motor_supply_over_86v <= 1'b0;
    `WT(!error_led)
    safe_torque_input_ok <= 1'b0;
    `WT(error_led)
    `CHK("sto", 1'b0, pwm_enable)
    safe_torque_input_ok <= 1'b1;
    axw(`DBMC_OFF_CTRL, 32'h20);
    `WT(use_hall_commutation)
    `CHK("hall", 1'b1, use_hall_commutation)
    `CHK("enc", 1'b1, use_encoder_position)
    $display("autorun test done");
    // halls held low through the hold time
    boot(1'b0, 8'h03, 3'h0);
    axw(`DBMC_OFF_CTRL, 32'h2);
    repeat (HC + 10) @(posedge aclk);
    hall_in <= 3'h7;
    axr(`DBMC_OFF_STATUS);
    `CHK("hl_state", 3'h4, rd[10:8])
    `CHK("hl_run", 1'b0, run_program)
    $display("hall hold test done");
    // no stored program
    boot(1'b0, 8'h03, 3'h7);
    repeat (10) @(posedge aclk);
    axr(`DBMC_OFF_STATUS);
    `CHK("np_state", 3'h4, rd[10:8])
    `CHK("np_run", 1'b0, run_program)
    $display("no program test done");
    // program stored but autorun word written before the halls release
    boot(1'b0, 8'h03, 3'h0);
    axw(`DBMC_OFF_CTRL, 32'h2);
    axw(`DBMC_OFF_NVM_ADDR, 32'h4000);
    axw(`DBMC_OFF_NVM_DATA, 32'h1);
    hall_in <= 3'h7;
    repeat (10) @(posedge aclk);
    axr(`DBMC_OFF_STATUS);
    `CHK("off_state", 3'h4, rd[10:8])
    `CHK("off_run", 1'b0, run_program)
    axr(`DBMC_OFF_NVM_ADDR);
    `CHK("nvm", 16'h4000, rd[15:0])
    axr(`DBMC_OFF_NVM_DATA);
    `CHK("nvm_word", 16'h0001, rd[15:0])
    $display("autorun off test done");
    // unconfigured network node
    boot(1'b1, 8'hFF, 3'h7);
    repeat (10) @(posedge aclk);
    `CHK("tx", 1'b0, can_tx_enable)
    axr(`DBMC_OFF_STATUS);
    `CHK("uc_state", 3'h3, rd[10:8])
    fl = ready_led;
    repeat (FC) @(posedge aclk);
    `CHK("flash", ~fl, ready_led)
    can_u.send(1'b0, acc);
    `CHK("other", 1'b0, acc)
    can_u.send(1'b1, acc);
    `CHK("cia", 1'b1, acc)
    axw(`DBMC_OFF_CONFIG, 32'h12);
    axw(`DBMC_OFF_CTRL, 32'h8);
    `WT(can_tx_enable)
    `CHK("uc_node", 8'h12, node_address)
    $display("unconfigured test done");
    // configured network node
    boot(1'b1, 8'h05, 3'h7);
    axw(`DBMC_OFF_CTRL, 32'h2);
    `WT(can_tx_enable)
    `CHK("co_node", 8'h05, node_address)
    `CHK("co_run", 1'b0, run_program)
    axr(`DBMC_OFF_CONFIG);
    `CHK("co_sel", 1'b1, rd[8])
    can_u.send(1'b0, acc);
    `CHK("co_acc", 1'b1, acc)
    axr(8'h40);
    `CHK("unmapped", 2'b10, rr)
    $display("configured test done");
    print_verdict();
  end
endmodule : test_drive_boot_mode_control
`default_nettype wire
